// >>> include/hpts_pkg.sv
// hpts_pkg: register map, field layout and codes of the hub port tuning and status bank
package hpts_pkg;

    // bus widths and port counts
    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 8;
    localparam int LINK_W       = 7;
    localparam int NUM_SS_PORTS = 3;
    localparam int NUM_HS_PORTS = 2;

    // register offsets
    localparam logic [15:0] OFF_SS_PORT1_LINK_STATUS  = 16'h65c0;
    localparam logic [15:0] OFF_HS_PORT2_DRIVE_TRIM   = 16'h68ca;
    localparam logic [15:0] OFF_HS_PORT2_SQUELCH_TRIM = 16'h68cc;
    localparam logic [15:0] OFF_SS_PORT2_LINK_STATUS  = 16'h69c0;
    localparam logic [15:0] OFF_HS_PORT3_DRIVE_TRIM   = 16'h6cca;
    localparam logic [15:0] OFF_HS_PORT3_SQUELCH_TRIM = 16'h6ccc;
    localparam logic [15:0] OFF_SS_PORT3_LINK_STATUS  = 16'h6dc0;

    // link status field positions
    localparam int LS_STATE_MSB = 7;
    localparam int LS_STATE_LSB = 4;
    localparam int LS_RSVD_BIT  = 3;
    localparam int LS_SUB_MSB   = 2;
    localparam int LS_SUB_LSB   = 0;

    // trim field positions
    localparam int TRIM_MSB = 2;
    localparam int TRIM_LSB = 0;
    localparam int RSVD_MSB = 7;
    localparam int RSVD_LSB = 3;

    // reset and fixed values
    localparam logic [7:0] RST_DRIVE_TRIM   = 8'h00;
    localparam logic [2:0] RST_SQUELCH_TRIM = 3'h0;
    localparam logic [6:0] RST_LINK_STATUS  = 7'h00;
    localparam logic       RSVD_BIT3_VAL    = 1'b0;
    localparam logic [4:0] SQ_RSVD_VAL      = 5'h00;
    localparam logic [7:0] RD_IDLE          = 8'h00;
    localparam logic [7:0] RD_UNMAPPED      = 8'h00;

    // squelch nominal trip point
    localparam int SQ_NOMINAL_MV = 100;

    // link state codes
    typedef enum logic [3:0] {
        LS_U0          = 4'h0,
        LS_U1          = 4'h1,
        LS_U2          = 4'h2,
        LS_U3          = 4'h3,
        LS_DISABLED    = 4'h4,
        LS_RX_DETECT   = 4'h5,
        LS_SS_INACTIVE = 4'h6,
        LS_POLLING     = 4'h7,
        LS_RECOVERY    = 4'h8,
        LS_HOT_RESET   = 4'h9,
        LS_COMPLIANCE  = 4'ha,
        LS_LOOPBACK    = 4'hb
    } hpts_link_state_t;

    // drive current trim codes
    typedef enum logic [2:0] {
        DRV_NOMINAL  = 3'h0,
        DRV_MINUS_5  = 3'h1,
        DRV_PLUS_10  = 3'h2,
        DRV_PLUS_20  = 3'h4
    } hpts_drive_code_t;

    // squelch trip trim codes
    typedef enum logic [2:0] {
        SQ_NOMINAL    = 3'h0,
        SQ_MINUS_12P5 = 3'h1,
        SQ_MINUS_25   = 3'h2,
        SQ_MINUS_50   = 3'h4
    } hpts_squelch_code_t;

endpackage : hpts_pkg

// >>> rtl/hpts_link_sync.sv
// hpts_link_sync: three-stage capture of a link status word from the link domain
`timescale 1ns/1ps
`default_nettype none

module hpts_link_sync #(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // word from the link domain
    input  wire logic [W-1:0] i_async,
    // agreed word
    output logic      [W-1:0] o_stable
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // synchroniser chain
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept only once two later stages agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stable <= hpts_pkg::RST_LINK_STATUS;
        end else if (s2 == s3) begin
            o_stable <= s3;
        end
    end

endmodule : hpts_link_sync

`default_nettype wire

// >>> rtl/hpts_regs.sv
// hpts_regs: downstream port drive trim, squelch trim and link status register bank
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module hpts_regs (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // register port
    input  wire logic [15:0] I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [7:0]  O_RDATA,
    // link state from the SS link machines
    input  wire logic [3:0]  I_P1_LINK_STATE,
    input  wire logic [2:0]  I_P1_LINK_SUBSTATE,
    input  wire logic [3:0]  I_P2_LINK_STATE,
    input  wire logic [2:0]  I_P2_LINK_SUBSTATE,
    input  wire logic [3:0]  I_P3_LINK_STATE,
    input  wire logic [2:0]  I_P3_LINK_SUBSTATE,
    // trims to the HS transceivers
    output logic      [2:0]  O_P2_DRIVE_TRIM,
    output logic      [2:0]  O_P2_SQUELCH_TRIM,
    output logic      [2:0]  O_P3_DRIVE_TRIM,
    output logic      [2:0]  O_P3_SQUELCH_TRIM
);

    logic [6:0] link_raw [hpts_pkg::NUM_SS_PORTS];
    logic [6:0] link_q   [hpts_pkg::NUM_SS_PORTS];
    logic [7:0] status   [hpts_pkg::NUM_SS_PORTS];
    logic [7:0] drv_q    [hpts_pkg::NUM_HS_PORTS];
    logic [2:0] sq_q     [hpts_pkg::NUM_HS_PORTS];
    logic [1:0] wr_drv;
    logic [1:0] wr_sq;
    logic [7:0] next_rdata;

    // gather link inputs per port
    assign link_raw[0] = {I_P1_LINK_STATE, I_P1_LINK_SUBSTATE};
    assign link_raw[1] = {I_P2_LINK_STATE, I_P2_LINK_SUBSTATE};
    assign link_raw[2] = {I_P3_LINK_STATE, I_P3_LINK_SUBSTATE};

    // per-port link status capture
    for (genvar p = 0; p < hpts_pkg::NUM_SS_PORTS; p++) begin : g_ss
        hpts_link_sync #(
            .W (hpts_pkg::LINK_W)
        ) u_sync (
            .i_clk    (I_CLK),
            .i_rst    (I_RST),
            .i_async  (link_raw[p]),
            .o_stable (link_q[p])
        );

        // status byte layout
        assign status[p] = {link_q[p][6:3],
                            hpts_pkg::RSVD_BIT3_VAL,
                            link_q[p][2:0]};
    end

    // per-port trim registers
    for (genvar h = 0; h < hpts_pkg::NUM_HS_PORTS; h++) begin : g_hs
        localparam logic [15:0] DRV_OFF = (h == 0) ? hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM
                                                   : hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM;
        localparam logic [15:0] SQ_OFF  = (h == 0) ? hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM
                                                   : hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM;

        assign wr_drv[h] = I_WR && (I_ADDR == DRV_OFF);
        assign wr_sq[h]  = I_WR && (I_ADDR == SQ_OFF);

        // whole byte kept, upper bits inert
        always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
                drv_q[h] <= hpts_pkg::RST_DRIVE_TRIM;
            end else if (wr_drv[h]) begin
                drv_q[h] <= I_WDATA;
            end
        end

        // only the code field is kept
        always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
                sq_q[h] <= hpts_pkg::RST_SQUELCH_TRIM;
            end else if (wr_sq[h]) begin
                sq_q[h] <= I_WDATA[hpts_pkg::TRIM_MSB:hpts_pkg::TRIM_LSB];
            end
        end
    end

    // trim outputs to the transceivers
    assign O_P2_DRIVE_TRIM   = drv_q[0][hpts_pkg::TRIM_MSB:hpts_pkg::TRIM_LSB];
    assign O_P3_DRIVE_TRIM   = drv_q[1][hpts_pkg::TRIM_MSB:hpts_pkg::TRIM_LSB];
    assign O_P2_SQUELCH_TRIM = sq_q[0];
    assign O_P3_SQUELCH_TRIM = sq_q[1];

    // read select
    always_comb begin
        next_rdata = hpts_pkg::RD_UNMAPPED;
        case (I_ADDR)
            hpts_pkg::OFF_SS_PORT1_LINK_STATUS: begin
                next_rdata = status[0];
            end
            hpts_pkg::OFF_SS_PORT2_LINK_STATUS: begin
                next_rdata = status[1];
            end
            hpts_pkg::OFF_SS_PORT3_LINK_STATUS: begin
                next_rdata = status[2];
            end
            hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM: begin
                next_rdata = drv_q[0];
            end
            hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM: begin
                next_rdata = drv_q[1];
            end
            hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM: begin
                next_rdata = {hpts_pkg::SQ_RSVD_VAL, sq_q[0]};
            end
            hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM: begin
                next_rdata = {hpts_pkg::SQ_RSVD_VAL, sq_q[1]};
            end
            default: begin
                next_rdata = hpts_pkg::RD_UNMAPPED;
            end
        endcase
    end

    // read data for one cycle only
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= hpts_pkg::RD_IDLE;
        end else if (I_RD) begin
            O_RDATA <= next_rdata;
        end else begin
            O_RDATA <= hpts_pkg::RD_IDLE;
        end
    end

    // checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    logic rd_st1;
    logic rd_st2;
    logic rd_st3;
    logic rd_drv2;
    logic rd_drv3;
    logic rd_sq2;
    logic rd_sq3;
    logic [3:0] rst_hist;

    assign rd_st1  = I_RD && (I_ADDR == hpts_pkg::OFF_SS_PORT1_LINK_STATUS);
    assign rd_st2  = I_RD && (I_ADDR == hpts_pkg::OFF_SS_PORT2_LINK_STATUS);
    assign rd_st3  = I_RD && (I_ADDR == hpts_pkg::OFF_SS_PORT3_LINK_STATUS);
    assign rd_drv2 = I_RD && (I_ADDR == hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM);
    assign rd_drv3 = I_RD && (I_ADDR == hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM);
    assign rd_sq2  = I_RD && (I_ADDR == hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM);
    assign rd_sq3  = I_RD && (I_ADDR == hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM);

    // marks the edges after reset while the link chains refill
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rst_hist <= 4'hf;
        end else begin
            rst_hist <= {rst_hist[2:0], 1'b0};
        end
    end

    property p_state_nibble;
        rd_st1 |=> O_RDATA[7:4] == $past(link_q[0][6:3]);
    endproperty
    AST_P1_STATE_NIBBLE: assert property (p_state_nibble)
        else $error("port 1 state nibble wrong");

    property p_substate;
        rd_st2 |=> O_RDATA[2:0] == $past(link_q[1][2:0]);
    endproperty
    AST_P2_SUBSTATE: assert property (p_substate)
        else $error("port 2 sub-state wrong");

    AST_STATUS_BIT3_FIXED: assert property (
        (rd_st1 || rd_st2 || rd_st3) |=> O_RDATA[3] == 1'b0)
        else $error("status bit 3 not zero");

    AST_P3_STATE_CODE: assert property (
        rd_st3 |=> O_RDATA == {$past(I_P3_LINK_STATE, 4), 1'b0, $past(I_P3_LINK_SUBSTATE, 4)}
                   || $past(link_raw[2], 4) != $past(link_raw[2], 5)
                   || $past(link_raw[2], 3) != $past(link_raw[2], 4)
                   || $past(link_raw[2], 2) != $past(link_raw[2], 3)
                   || $past(rst_hist) != 4'h0)
        else $error("port 3 link code not carried through");

    property p_drive_follow(logic wr, logic [2:0] trim);
        wr |=> trim == $past(I_WDATA[2:0]);
    endproperty
    AST_P2_DRIVE_WRITE: assert property (p_drive_follow(wr_drv[0], O_P2_DRIVE_TRIM))
        else $error("port 2 drive trim not written");
    AST_P3_DRIVE_WRITE: assert property (p_drive_follow(wr_drv[1], O_P3_DRIVE_TRIM))
        else $error("port 3 drive trim not written");

    AST_P3_DRIVE_HOLD: assert property (
        !wr_drv[1] |=> $stable(O_P3_DRIVE_TRIM))
        else $error("port 3 drive trim moved without write");

    AST_DRIVE_RSVD_KEPT: assert property (
        (wr_drv[0] ##1 (rd_drv2 && !wr_drv[0])) |=> O_RDATA == $past(I_WDATA, 2))
        else $error("drive trim byte not kept");

    AST_P3_DRIVE_READ: assert property (
        rd_drv3 |=> O_RDATA == $past(drv_q[1]))
        else $error("port 3 drive trim read wrong");

    AST_P2_SQUELCH_WRITE: assert property (
        wr_sq[0] |=> O_P2_SQUELCH_TRIM == $past(I_WDATA[2:0]))
        else $error("port 2 squelch trim not written");

    AST_P3_SQUELCH_WRITE: assert property (
        wr_sq[1] |=> O_P3_SQUELCH_TRIM == $past(I_WDATA[2:0]))
        else $error("port 3 squelch trim not written");

    AST_P2_DRIVE_HOLD: assert property (
        !wr_drv[0] |=> $stable(O_P2_DRIVE_TRIM))
        else $error("port 2 drive trim moved without write");

    AST_P2_SQUELCH_HOLD: assert property (
        !wr_sq[0] |=> $stable(O_P2_SQUELCH_TRIM))
        else $error("port 2 squelch trim moved without write");

    AST_P3_SQUELCH_HOLD: assert property (
        !wr_sq[1] [*2] |-> $stable(O_P3_SQUELCH_TRIM))
        else $error("port 3 squelch trim moved without write");

    AST_SQUELCH_RSVD_ZERO: assert property (
        (rd_sq2 || rd_sq3) |=> O_RDATA[7:3] == 5'h00)
        else $error("squelch reserved bits not zero");

    AST_SQUELCH_READBACK: assert property (
        (wr_sq[1] ##1 (rd_sq3 && !wr_sq[1])) |=> O_RDATA[2:0] == $past(I_WDATA[2:0], 2))
        else $error("squelch code not read back");

    AST_RDATA_IDLE: assert property (
        !I_RD |=> O_RDATA == 8'h00)
        else $error("read data not idle");

    COV_LOOPBACK_READ: cover property (
        rd_st1 && link_q[0][6:3] == hpts_pkg::LS_LOOPBACK);

    COV_DRIVE_PLUS_20: cover property (
        wr_drv[1] && I_WDATA[2:0] == hpts_pkg::DRV_PLUS_20 ##1 rd_drv3);

    COV_SQUELCH_MINUS_50: cover property (
        wr_sq[0] && I_WDATA[2:0] == hpts_pkg::SQ_MINUS_50 ##1 rd_sq2);

    COV_BACK_TO_BACK_READS: cover property (
        rd_st2 ##1 rd_st3);

endmodule : hpts_regs

`default_nettype wire

// >>> test/hpts_regs_tb_top.sv
// hpts_regs_tb_top: self-checking bench for the port tuning and link status register bank
`timescale 1ns/1ps
`default_nettype none

module hpts_regs_tb_top;

    typedef struct packed {
        logic [15:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic        t;
    } hpts_tb_row_t;

    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [15:0] addr  = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [7:0]  rdata;
    logic [3:0]  st [3] = '{4'h0, 4'h0, 4'h0};
    logic [2:0]  sub [3] = '{3'h0, 3'h0, 3'h0};
    logic [2:0]  drv2;
    logic [2:0]  sq2;
    logic [2:0]  drv3;
    logic [2:0]  sq3;
    logic [7:0]  got;
    logic [7:0]  d;
    int          n_fail       = 0;
    int          total_checks = 0;

    localparam logic [15:0] STAT [3] = '{hpts_pkg::OFF_SS_PORT1_LINK_STATUS,
        hpts_pkg::OFF_SS_PORT2_LINK_STATUS, hpts_pkg::OFF_SS_PORT3_LINK_STATUS};

    // ordinary cases: write, read back, trim output
    hpts_tb_row_t rows [6] = '{
        '{hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM,   8'hfc, 8'hfc, 1'b1},
        '{hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM, 8'hfd, 8'h05, 1'b1},
        '{hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM,   8'h2b, 8'h2b, 1'b1},
        '{hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM, 8'h7a, 8'h02, 1'b1},
        '{16'h68cb,                            8'hff, 8'h00, 1'b0},
        '{16'h65c1,                            8'h5a, 8'h00, 1'b0}};

    hpts_regs i_dut (
        .I_CLK              (clk),
        .I_RST              (rst),
        .I_ADDR             (addr),
        .I_WDATA            (wdata),
        .I_WR               (wr),
        .I_RD               (rd),
        .O_RDATA            (rdata),
        .I_P1_LINK_STATE    (st[0]),
        .I_P1_LINK_SUBSTATE (sub[0]),
        .I_P2_LINK_STATE    (st[1]),
        .I_P2_LINK_SUBSTATE (sub[1]),
        .I_P3_LINK_STATE    (st[2]),
        .I_P3_LINK_SUBSTATE (sub[2]),
        .O_P2_DRIVE_TRIM    (drv2),
        .O_P2_SQUELCH_TRIM  (sq2),
        .O_P3_DRIVE_TRIM    (drv3),
        .O_P3_SQUELCH_TRIM  (sq3)
    );

    always #2 clk = ~clk;

    // one bus cycle, driven just after the rising edge
    task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= v;
    endtask : cyc

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        cyc(1'b1, 1'b0, a, v);
    endtask : wr_reg

    // read strobe, then one idle cycle while the data stand
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        cyc(1'b0, 1'b1, a, 8'h00);
        cyc(1'b0, 1'b0, a, 8'h00);
        @(negedge clk);
        v = rdata;
    endtask : rd_reg

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_byte

    task automatic chk_trim(input logic [2:0] g, input logic [2:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_trim

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, total_checks, n_fail);
    endtask : end_test

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [2:0] trim_of(input logic [15:0] a);
        case (a)
            hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM:   return drv2;
            hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM: return sq2;
            hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM:   return drv3;
            default:                             return sq3;
        endcase
    endfunction : trim_of

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        chk_byte(rdata, 8'h00);
        chk_trim(drv2 | sq2 | drv3 | sq3, 3'h0);
        rst <= 1'b0;
        end_test("reset");

        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, got);
            chk_byte(got, rows[i].e);
            if (rows[i].t) begin
                chk_trim(trim_of(rows[i].a), rows[i].d[2:0]);
            end
        end
        chk_trim(drv2, 3'h4);
        chk_trim(sq3, 3'h2);
        rd_reg(hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM, got);
        wr_reg(hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM, {got[7:3], 3'h2});
        rd_reg(hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM, got);
        chk_byte(got, 8'hfa);
        chk_trim(drv2, 3'h2);
        end_test("rows");

        // every trim code, writes and reads back to back
        for (int c = 0; c < 8; c++) begin
            d = {5'(7 - c), 3'(c)};
            wr_reg(hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM, d);
            wr_reg(hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM, d);
            wr_reg(hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM, ~d);
            wr_reg(hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM, ~d);
            rd_reg(hpts_pkg::OFF_HS_PORT2_DRIVE_TRIM, got);
            chk_byte(got, d);
            rd_reg(hpts_pkg::OFF_HS_PORT2_SQUELCH_TRIM, got);
            chk_byte(got, {5'h00, d[2:0]});
            rd_reg(hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM, got);
            chk_byte(got, ~d);
            rd_reg(hpts_pkg::OFF_HS_PORT3_SQUELCH_TRIM, got);
            chk_byte(got, {5'h00, ~d[2:0]});
            chk_trim(drv2, d[2:0]);
            chk_trim(sq2, d[2:0]);
            chk_trim(drv3, ~d[2:0]);
            chk_trim(sq3, ~d[2:0]);
        end
        @(negedge clk);
        chk_byte(rdata, 8'h00);
        end_test("codes");

        // every link state code on all three ports
        for (int c = 0; c < 12; c++) begin
            @(posedge clk);
            st[0]  <= 4'(c);
            sub[0] <= 3'(c);
            st[1]  <= 4'(11 - c);
            sub[1] <= ~3'(c);
            st[2]  <= 4'(c) ^ 4'h3;
            sub[2] <= 3'(c + 3);
            repeat (6) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
            for (int p = 0; p < 3; p++) begin
                rd_reg(STAT[p], got);
                chk_byte(got, {st[p], 1'b0, sub[p]});
            end
        end
        wr_reg(hpts_pkg::OFF_SS_PORT2_LINK_STATUS, 8'hff);
        rd_reg(hpts_pkg::OFF_SS_PORT2_LINK_STATUS, got);
        chk_byte(got, {st[1], 1'b0, sub[1]});
        end_test("status");

        // one-cycle glitch on a link input is never shown
        @(posedge clk);
        st[0] <= 4'h0;
        @(posedge clk);
        st[0] <= 4'hb;
        for (int k = 0; k < 4; k++) begin
            rd_reg(STAT[0], got);
            chk_byte(got, 8'hb3);
        end
        end_test("glitch");

        // reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk_trim(drv2 | sq2 | drv3 | sq3, 3'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(hpts_pkg::OFF_HS_PORT3_DRIVE_TRIM, got);
        chk_byte(got, hpts_pkg::RST_DRIVE_TRIM);
        repeat (4) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
        rd_reg(STAT[2], got);
        chk_byte(got, {st[2], 1'b0, sub[2]});
        end_test("mid reset");

        report_and_stop();
    end

endmodule : hpts_regs_tb_top

`default_nettype wire
